// File: cfsg_pkg.sv
// Package for the clock fan-out block with source select and glitch-free gating.
// Assumes a single core clock; all pins are sampled as synchronous levels.
package cfsg_pkg;
	localparam int          CFSG_NUM_OUT   = 12;          // Outputs in the bank
	localparam logic        CFSG_SEL_DIFF  = 1'h0;        // Select level for the differential ref
	localparam logic        CFSG_SEL_TEST  = 1'h1;        // Select level for the test clock
	localparam logic        CFSG_LVL_RST   = 1'h0;        // Clock level after reset
	localparam logic        CFSG_EN_RST    = 1'h0;        // Captured enable after reset
	localparam logic [11:0] CFSG_BANK_LOW  = 12'h000;     // Bank driven low
	localparam logic [11:0] CFSG_BANK_HIGH = 12'hfff;     // Every bit of the bank set

	// Output bank: levels and drive enables travel together
	typedef struct packed {
		logic [CFSG_NUM_OUT-1:0] q;
		logic [CFSG_NUM_OUT-1:0] oe;
	} cfsg_bank_t;
endpackage : cfsg_pkg

// File: cfsg_top.sv
// Clock fan-out: source select, enable captured at falling edge, twelve gated outputs.
// Assumes clock inputs are slow against core_clk_i and sampled as plain levels.
// Assumes each phase of the selected clock lasts at least one core cycle.
// The drive enables leave the tristate buffers to the pad ring above this block.
//
// Notes on behaviour
// - Select low routes the differential reference, high routes the test clock.
// - Enable is captured only at each falling edge of the selected clock.
// - Captured enable high passes the clock; low holds every output low.
// - Enabling or disabling never makes a glitch or runt pulse.
// - Float input low releases all drivers; high drives the gated clock.
// - Twelve outputs share one selected, gated clock and common controls.
`timescale 1ns/100ps
module cfsg_top
	import cfsg_pkg::*;
(
	input  wire logic       core_clk_i,
	input  wire logic       rst_n_i,
	input  wire logic       diff_ref_clock_in_p_i,
	input  wire logic       diff_ref_clock_in_n_i,
	input  wire logic       test_clock_in_i,
	input  wire logic       clock_source_select_i,
	input  wire logic       sync_oe_i,
	input  wire logic       output_float_n_i,
	output cfsg_bank_t      bank_o
);

	// Sampled clock level, captured enable and the two output banks
	logic             clk_lvl_reg;
	logic             clk_lvl_next;
	logic             en_cap_reg;
	logic             fall_edge;
	logic [11:0]      q_reg;
	logic [11:0]      oe_reg;

	// Source mux; differential pair resolves high when p above n
	always_comb begin
		if (clock_source_select_i == CFSG_SEL_TEST) begin
			clk_lvl_next = test_clock_in_i;
		end else begin
			clk_lvl_next = diff_ref_clock_in_p_i & ~diff_ref_clock_in_n_i;
		end
	end

	// Fall seen between two samples; a phase shorter than a core cycle is missed
	assign fall_edge = clk_lvl_reg & ~clk_lvl_next;

	// Selected clock level history
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			clk_lvl_reg <= CFSG_LVL_RST;
		end else begin
			clk_lvl_reg <= clk_lvl_next;
		end
	end

	// Enable capture at the falling edge only
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			en_cap_reg <= CFSG_EN_RST;
		end else if (fall_edge) begin
			en_cap_reg <= sync_oe_i;
		end
	end

	// Gated clock bank; the new enable lands while the clock is low
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			q_reg <= CFSG_BANK_LOW;
		end else if (en_cap_reg) begin
			q_reg <= {CFSG_NUM_OUT{clk_lvl_next}};
		end else begin
			q_reg <= CFSG_BANK_LOW;
		end
	end

	// Driver enables follow the float input
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			oe_reg <= CFSG_BANK_LOW;
		end else begin
			oe_reg <= output_float_n_i ? CFSG_BANK_HIGH : CFSG_BANK_LOW;
		end
	end

	assign bank_o.q  = q_reg;
	assign bank_o.oe = oe_reg;

	// Checks run on the core clock and stay quiet while reset is held
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);

	// Select high: sampled level follows the test clock
	property p_route;
		$past(rst_n_i) && $past(clock_source_select_i == CFSG_SEL_TEST) |-> clk_lvl_reg == $past(test_clock_in_i);
	endproperty
	a_route: assert property (p_route) else $error("wrong clock source");

	// Select low: sampled level follows the differential pair
	property p_route_diff;
		$past(rst_n_i) && $past(clock_source_select_i == CFSG_SEL_DIFF) |->
			clk_lvl_reg == ($past(diff_ref_clock_in_p_i) && !$past(diff_ref_clock_in_n_i));
	endproperty
	a_route_diff: assert property (p_route_diff) else $error("wrong differential level");

	// Captured enable moves only on a falling edge
	property p_capture;
		$past(rst_n_i) && $changed(en_cap_reg) |-> $fell(clk_lvl_reg);
	endproperty
	a_capture: assert property (p_capture) else $error("enable moved off edge");

	// Output is clock gated by the enable held before
	property p_gate;
		$past(rst_n_i) |-> q_reg == {CFSG_NUM_OUT{clk_lvl_reg & $past(en_cap_reg)}};
	endproperty
	a_gate: assert property (p_gate) else $error("gating mismatch");

	// Outputs fall only together with the clock
	property p_no_runt;
		$past(rst_n_i) && $fell(q_reg[0]) |-> $fell(clk_lvl_reg);
	endproperty
	a_no_runt: assert property (p_no_runt) else $error("runt high phase");

	// Drivers follow the float input one cycle later
	property p_float;
		$past(rst_n_i) |-> oe_reg == {CFSG_NUM_OUT{$past(output_float_n_i)}};
	endproperty
	a_float: assert property (p_float) else $error("float control wrong");

	// All outputs identical
	property p_bank;
		q_reg == {CFSG_NUM_OUT{q_reg[0]}} && oe_reg == {CFSG_NUM_OUT{oe_reg[0]}};
	endproperty
	a_bank: assert property (p_bank) else $error("bank bits differ");

	// Outputs rise only with the clock
	property p_low_switch;
		$past(rst_n_i) && $rose(q_reg[0]) |-> $rose(clk_lvl_reg);
	endproperty
	a_low_switch: assert property (p_low_switch) else $error("gate opened mid high");

	// First edge after reset shows every register at its reset value
	property p_reset_state;
		!$past(rst_n_i) |-> q_reg == CFSG_BANK_LOW && oe_reg == CFSG_BANK_LOW &&
			en_cap_reg == CFSG_EN_RST &&
			clk_lvl_reg == CFSG_LVL_RST;
	endproperty
	a_reset_state: assert property (p_reset_state) else $error("reset state wrong");

	// Closed gate holds the whole bank low
	property p_gate_closed;
		$past(rst_n_i) && !$past(en_cap_reg) |-> q_reg == CFSG_BANK_LOW;
	endproperty
	a_gate_closed: assert property (p_gate_closed) else $error("bank not held low");

	// Open gate passes the sampled clock level
	property p_gate_open;
		$past(rst_n_i) && $past(en_cap_reg) |-> q_reg[0] == clk_lvl_reg;
	endproperty
	a_gate_open: assert property (p_gate_open) else $error("clock not passed");

	// Without a falling edge the captured enable keeps its value
	property p_hold_enable;
		$past(rst_n_i) && !$past(fall_edge) |-> $stable(en_cap_reg);
	endproperty
	a_hold_enable: assert property (p_hold_enable) else $error("enable not held");

	// At a falling edge the enable input is taken
	property p_take_enable;
		$past(rst_n_i) && $past(fall_edge) |-> en_cap_reg == $past(sync_oe_i);
	endproperty
	a_take_enable: assert property (p_take_enable) else $error("enable not taken");

	// Float input low releases every driver
	property p_float_off;
		$past(rst_n_i) && !$past(output_float_n_i) |-> oe_reg == CFSG_BANK_LOW;
	endproperty
	a_float_off: assert property (p_float_off) else $error("drivers not released");

	// Float input high drives every output
	property p_float_on;
		$past(rst_n_i) && $past(output_float_n_i) |-> oe_reg == CFSG_BANK_HIGH;
	endproperty
	a_float_on: assert property (p_float_on) else $error("drivers not enabled");

	// A high phase already begun is never cut short
	property p_high_whole;
		$past(rst_n_i) && $past(q_reg[0]) && clk_lvl_reg |->
			q_reg[0];
	endproperty
	a_high_whole: assert property (p_high_whole) else $error("high phase cut");

	// Outputs stay low while the selected clock is low
	property p_low_whole;
		$past(rst_n_i) && !clk_lvl_reg |-> !q_reg[0];
	endproperty
	a_low_whole: assert property (p_low_whole) else $error("output high in low phase");

	// An output high needs the selected clock high
	property p_q_needs_clock;
		$past(rst_n_i) && q_reg[0] |-> clk_lvl_reg;
	endproperty
	a_q_needs_clock: assert property (p_q_needs_clock) else $error("output high without clock");

	// The gate changes only while the output is low
	property p_switch_low;
		$past(rst_n_i) && $changed(en_cap_reg) |-> !q_reg[0];
	endproperty
	a_switch_low: assert property (p_switch_low) else $error("gate moved while high");

	// Opening the gate starts from a low bank
	property p_open_low;
		$past(rst_n_i) && $rose(en_cap_reg) |-> q_reg == CFSG_BANK_LOW;
	endproperty
	a_open_low: assert property (p_open_low) else $error("gate opened on high bank");

	// Closing the gate leaves the bank low at once
	property p_close_low;
		$past(rst_n_i) && $fell(en_cap_reg) |-> q_reg == CFSG_BANK_LOW;
	endproperty
	a_close_low: assert property (p_close_low) else $error("gate closed on high bank");

endmodule : cfsg_top

// File: cfsg_clk_src.sv
// Board clock sources: differential reference and single-ended test clock.
// Assumes the bench steps them from the falling edge of core_clk_i.
`timescale 1ns/100ps
module cfsg_clk_src (
	input  wire logic core_clk_i,
	input  wire logic run_diff_i,
	input  wire logic run_test_i,
	output logic      diff_p_o,
	output logic      diff_n_o,
	output logic      test_o
);
	logic [2:0] cnt_reg = 3'h0;
	logic       dp_reg  = 1'h0;
	logic       tc_reg  = 1'h0;
	// Each source stands low outside its burst; rates differ so leaks show
	always @(negedge core_clk_i) begin
		cnt_reg <= cnt_reg + 3'h1;
		dp_reg  <= run_diff_i & cnt_reg[1];
		tc_reg  <= run_test_i & cnt_reg[2];
	end
	assign diff_p_o = dp_reg;
	assign diff_n_o = ~dp_reg;   // Complement side of the pair
	assign test_o   = tc_reg;
endmodule : cfsg_clk_src

// File: clock_fanout_sync_gate_test.sv
// Self-checking bench for the clock fan-out block.
// Assumes the source model above; inputs change at the falling core edge.
`timescale 1ns/100ps
module clock_fanout_sync_gate_test;
	import cfsg_pkg::*;
	logic        core_clk_i = 1'h0;
	logic        rst_n_i    = 1'h0;
	logic        sel        = 1'h0;
	logic        oe_in      = 1'h0;
	logic        float_n    = 1'h1;
	logic        run_d      = 1'h0;
	logic        run_t      = 1'h0;
	logic        dp, dn, tc, prev_reg, en_reg;
	logic [11:0] q_ref, oe_ref;
	cfsg_bank_t  bank;
	int          err_count   = 0;
	int          comparisons = 0;
	int          high_cnt    = 0;
	wire         lvl = sel ? tc : (dp & ~dn);
	cfsg_clk_src u_src (.core_clk_i(core_clk_i), .run_diff_i(run_d), .run_test_i(run_t),
		.diff_p_o(dp), .diff_n_o(dn), .test_o(tc));
	cfsg_top u_dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .diff_ref_clock_in_p_i(dp),
		.diff_ref_clock_in_n_i(dn), .test_clock_in_i(tc), .clock_source_select_i(sel),
		.sync_oe_i(oe_in), .output_float_n_i(float_n), .bank_o(bank));
	// Reference: enable taken at a sampled fall, bank follows one edge later
	always @(posedge core_clk_i) begin
		prev_reg <= rst_n_i & lvl;
		en_reg   <= !rst_n_i ? 1'h0 : (prev_reg & ~lvl) ? oe_in : en_reg;
		q_ref    <= (rst_n_i & en_reg & lvl) ? CFSG_BANK_HIGH : CFSG_BANK_LOW;
		oe_ref   <= (rst_n_i & float_n) ? CFSG_BANK_HIGH : CFSG_BANK_LOW;
	end
	task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR %0t bank %h expected %h", $time, seen, exp);
		end
	endtask : chk
	// Step n cycles, comparing the whole bank each cycle
	task automatic run(input int n);
		repeat (n) begin
			@(negedge core_clk_i);
			chk(bank.q, q_ref);
			chk(bank.oe, oe_ref);
			if (bank.q === CFSG_BANK_HIGH) begin
				high_cnt++;
			end
		end
	endtask : run
	// Differential source drives the bank; the test clock runs beside it as a leak probe
	task automatic t_diff_source();
		run_d    = 1'h1;
		run_t    = 1'h1;
		oe_in    = 1'h1;
		high_cnt = 0;
		run(24);
		chk({11'h000, high_cnt != 0}, 12'h001);
	endtask : t_diff_source
	// Test clock selected while enabled; the differential source keeps running
	task automatic t_test_source();
		sel      = 1'h1;
		high_cnt = 0;
		run(24);
		chk({11'h000, high_cnt != 0}, 12'h001);
	endtask : t_test_source
	// Disable between falling edges, a short pulse across a falling edge so the gate stays open, then a held disable
	task automatic t_disable();
		oe_in = 1'h0;
		run(5);
		oe_in = 1'h1;
		run(3);
		oe_in = 1'h0;
		run(9);
		repeat (5) begin
			run(1);
			chk(bank.q, CFSG_BANK_LOW);
		end
	endtask : t_disable
	// Drivers released with the gate open, then taken back
	task automatic t_float();
		oe_in   = 1'h1;
		float_n = 1'h0;
		run(10);
		chk(bank.oe, CFSG_BANK_LOW);
		float_n = 1'h1;
		run(2);
		chk(bank.oe, CFSG_BANK_HIGH);
	endtask : t_float
	// Source stops low while enabled; the bank must settle low
	task automatic t_source_stop();
		run_t = 1'h0;
		run(8);
		chk(bank.q, CFSG_BANK_LOW);
	endtask : t_source_stop
	// Reset in mid-run clears the bank; the enable must be captured anew
	task automatic t_reset_mid();
		run_t   = 1'h1;
		rst_n_i = 1'h0;
		run(3);
		chk(bank.q, CFSG_BANK_LOW);
		chk(bank.oe, CFSG_BANK_LOW);
		rst_n_i  = 1'h1;
		high_cnt = 0;
		run(20);
		chk({11'h000, high_cnt != 0}, 12'h001);
	endtask : t_reset_mid
	task automatic results();
		$display("comparisons %0d errors %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : results
	initial begin
		forever #25 core_clk_i = ~core_clk_i;
	end
	// Hang guard
	initial begin
		repeat (2000) @(posedge core_clk_i);
		err_count++;
		results();
	end
	initial begin
		repeat (3) @(negedge core_clk_i);
		rst_n_i = 1'h1;
		t_diff_source();
		t_test_source();
		t_disable();
		t_float();
		t_source_stop();
		t_reset_mid();
		results();
	end
endmodule : clock_fanout_sync_gate_test
